// ### bso_gate_if.sv
// interface: low-side gate path between sequencer and pulse shaper
interface bso_gate_if;
    logic pwm_low;    // raw low-side request
    logic allow;      // switching permitted
    logic gate_low;   // shaped low gate
    logic window;     // current check window open
    modport seq (output pwm_low, output allow, input gate_low, input window);
    modport shp (input pwm_low, input allow, output gate_low, output window);
endinterface : bso_gate_if

// ### bso_low_gate_shaper.sv
// module: low-side pulse stretcher and current-check window
module bso_low_gate_shaper
    import bso_pkg::*;
(
    input  wire logic i_mclk,      // system clock
    input  wire logic i_rst,       // async reset, high
    input  wire logic i_period,    // one pulse per switching period
    bso_gate_if.shp   g            // gate path
);
    logic [7:0] width;     // cycles the gate has been high
    logic [1:0] narrow;    // consecutive narrow periods
    logic       was_wide;  // this period reached the minimum
    logic [7:0] stretch;   // forced-high cycles left
    logic       force_on;

    assign force_on   = (stretch != 8'h00);
    assign g.gate_low = g.allow & (g.pwm_low | force_on);

    // width measure; window opens after blanking, clears on the first edge after gate fall
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            width  <= 8'h00;
            g.window <= 1'b0;
        end else if (!g.gate_low) begin
            width  <= 8'h00;
            g.window <= 1'b0;               // see RULE_15
        end else begin
            if (width != 8'hFF)
                width <= width + 8'h01;
            g.window <= (width >= 8'(BLANK_CYC - 1)); // see RULE_15
        end
    end

    // count narrow periods; force third one to minimum width
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            narrow   <= 2'h0;
            was_wide <= 1'b0;
            stretch  <= 8'h00;
        end else begin
            if (g.gate_low && width >= 8'(MIN_LOW_CYC - 1))
                was_wide <= 1'b1;
            if (force_on)
                stretch <= stretch - 8'h01;
            if (i_period) begin
                was_wide <= 1'b0;
                if (was_wide || !g.allow) begin
                    narrow <= 2'h0;
                // two narrow periods ended: this third one is forced
                end else if (narrow == 2'(NARROW_LIMIT - 2)) begin
                    narrow  <= 2'h0;
                    stretch <= 8'(MIN_LOW_CYC); // see RULE_16
                end else begin
                    narrow <= narrow + 2'h1;
                end
            end
        end
    end
endmodule : bso_low_gate_shaper

// ### bso_pkg.sv
// package: constants and types for the start-up and overcurrent sequencer
// Overview of operation
// RULE_01: start initialization when bias supply passes por
// RULE_02: hold off while enable pin held low
// RULE_03: wait fixed settling delay after enable rises
// RULE_04: low gate off, trip-set current on meanwhile
// RULE_05: counter and dac sample trip-set voltage
// RULE_06: hold sampled set point until power loss
// RULE_07: start soft-start when sample completes
// RULE_08: ramp reference in 64 equal steps
// RULE_09: enable error amp shortly after ramp start
// RULE_10: low pre-bias: switches off until ramp passes
// RULE_11: high pre-bias: switches off until ramp end
// RULE_12: re-enable repeats full init with new sample
// RULE_13: no new sample during overcurrent retries
// RULE_14: overcurrent: off, two dummy waits, one retry
// RULE_15: check current 200ns after low gate rise
// RULE_16: stretch third narrow low pulse to 425ns
// RULE_17: disable stops oscillator, both gates low
// RULE_18: overcurrent detection active during soft-start
// RULE_19: trip during retry restarts dummy waits at once
// RULE_20: all delays counted, reset returns to idle
package bso_pkg;
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned SETTLE_US     = 6800;
    localparam int unsigned SS_US         = 6800;
    localparam int unsigned SAMPLE_MAX_US = 3400;
    localparam int unsigned BLANK_NS      = 200;
    localparam int unsigned MIN_LOW_NS    = 425;
    localparam int unsigned INIT_US       = 100;
    localparam int unsigned SETTLE_CYC    = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SS_CYC        = SS_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SAMPLE_CYC    =
        SAMPLE_MAX_US * (CLK_HZ / 1_000_000);
    localparam int unsigned INIT_CYC      = INIT_US * (CLK_HZ / 1_000_000);
    // blanking time and least time both round up
    localparam int unsigned BLANK_CYC     =
        (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned MIN_LOW_CYC   =
        (MIN_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SS_STEPS      = 64;
    localparam int unsigned DAC_W         = 6;
    localparam int unsigned DUMMY_RUNS    = 2;
    localparam int unsigned NARROW_LIMIT  = 3;
    localparam logic [DAC_W-1:0] DAC_FULL = 6'h3F;
    localparam logic [DAC_W-1:0] DAC_ZERO = 6'h00;

    typedef enum logic [2:0] {
        BSO_IDLE, BSO_SETTLE, BSO_SAMPLE, BSO_SOFT, BSO_RUN, BSO_DUMMY
    } bso_state_type;
endpackage : bso_pkg

// ### bso_seq_monitor.sv
// checker: port-level timing and safety properties of the sequencer
module bso_seq_monitor
    import bso_pkg::*;
(
    input wire logic             i_mclk,      // clock
    input wire logic             i_rst,       // async reset, high
    input wire logic             i_por_ok,    // bias above por
    input wire logic             i_en_high,   // enable pin above trip
    input wire logic             i_oc_cmp,    // low-side over trip
    input wire logic [DAC_W-1:0] o_ss_ref,    // ramp code
    input wire logic [DAC_W-1:0] o_oc_dac,    // held trip code
    input wire logic             o_trip_set_pin_src,  // trip-set current on
    input wire logic             o_osc_run,   // oscillator enable
    input wire logic             o_gate_high, // high-side gate
    input wire logic             o_gate_low,  // low-side gate
    input wire logic             o_oc_trip,   // overcurrent pulse
    input wire logic             o_ss_done    // soft-start complete
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // oscillator follows the bias and enable comparators together
    a_osc_run_follows: assert property (
        o_osc_run == (i_por_ok && i_en_high))
        else $error("oscillator enable does not follow bias and enable");
    a_gates_off_disabled: assert property (
        !o_osc_run |-> !o_gate_high && !o_gate_low)
        else $error("gate driven while disabled");
    a_disable_to_idle: assert property (
        !o_osc_run |=> !o_trip_set_pin_src && !o_ss_done)
        else $error("sequence not back to idle after disable");
    a_trip_set_pin_gate_off: assert property (
        o_trip_set_pin_src |-> !o_gate_low)
        else $error("low gate on while trip-set current flows");
    a_dac_held: assert property (
        o_ss_done ##1 o_osc_run |-> $stable(o_oc_dac))
        else $error("held trip code changed");
    a_ramp_single_step: assert property (
        $changed(o_ss_ref) && o_ss_ref != DAC_ZERO |->
            o_ss_ref == DAC_W'($past(o_ss_ref) + 1))
        else $error("ramp code moved by more than one step");
    a_done_at_full: assert property (
        o_ss_done |-> o_ss_ref == DAC_FULL)
        else $error("soft-start done before full ramp");
    // the trip masks the gate at once, so look at the cycles before
    a_trip_in_window: assert property (
        o_oc_trip |-> i_oc_cmp && $past(o_gate_low) &&
            $past(o_gate_low, 5))
        else $error("trip outside the low gate window");
    // ringing after the low gate edge must never trip
    a_blank_after_rise: assert property (
        $rose(o_gate_low) |-> !o_oc_trip [*5])
        else $error("trip inside the blanking time");
    a_trip_shuts_off: assert property (
        o_oc_trip |=> !o_gate_high && !o_gate_low && !o_ss_done)
        else $error("output not shut off after trip");
    // a forced low pulse must never overlap the high side
    a_no_shoot_through: assert property (
        !(o_gate_high && o_gate_low))
        else $error("high and low gates on together");

    c_ss_done: cover property ($rose(o_ss_done));
    c_oc_trip: cover property ($rose(o_oc_trip));
    c_sample_end: cover property ($fell(o_trip_set_pin_src));
endmodule : bso_seq_monitor

bind bso_sequencer bso_seq_monitor u_mon (.i_mclk, .i_rst, .i_por_ok,
    .i_en_high, .i_oc_cmp, .o_ss_ref, .o_oc_dac, .o_trip_set_pin_src, .o_osc_run,
    .o_gate_high, .o_gate_low, .o_oc_trip, .o_ss_done);

// ### bso_sequencer.sv
// module: start-up, set-point sample, soft-start and hiccup sequencer
module bso_sequencer
    import bso_pkg::*;
(
    input  wire logic                    i_mclk,      // 25 MHz clock
    input  wire logic                    i_rst,       // power-on reset
    input  wire logic                    i_por_ok,    // bias above por
    input  wire logic                    i_en_high,   // en pin above trip
    input  wire logic                    i_trip_set_pin_cmp,  // trip-set > dac
    input  wire logic                    i_oc_cmp,    // low-side over trip
    input  wire logic                    i_vout_gt_ss,// output above ramp
    input  wire logic                    i_pwm_high,  // pwm high request
    input  wire logic                    i_pwm_low,   // pwm low request
    input  wire logic                    i_period,    // period start pulse
    output logic [bso_pkg::DAC_W-1:0]    o_ss_ref,    // soft-start ref code
    output logic [bso_pkg::DAC_W-1:0]    o_oc_dac,    // held trip code
    output logic                         o_trip_set_pin_src,  // trip-set current on
    output logic                         o_ea_en,     // error amp drives pin
    output logic                         o_osc_run,   // oscillator enable
    output logic                         o_gate_high, // high-side gate
    output logic                         o_gate_low,  // low-side gate
    output logic                         o_oc_trip,   // overcurrent pulse
    output logic                         o_ss_done    // soft-start complete
);
    import bso_pkg::*;

    bso_state_type state;
    bso_state_type next_state;
    logic [17:0]   tmr;          // delay counter
    logic [17:0]   step_tmr;     // soft-start step timer
    logic          dummy_cnt;    // dummy time-outs done
    logic          real_run;     // soft-start is a real attempt
    logic          held;         // set point valid
    logic          passed_vout;  // ramp has passed pre-bias
    logic          oc_hit;
    logic          enabled;
    bso_gate_if    g ();

    // divide a span into 64 equal step intervals
    function automatic logic [17:0] step_len(input int unsigned span);
        step_len = 18'(span / SS_STEPS);
    endfunction : step_len

    assign enabled = i_por_ok & i_en_high;            // see RULE_01 RULE_02
    // detection live whenever switching, ramp included
    assign oc_hit  = g.window & i_oc_cmp;             // see RULE_15 RULE_18

    // state decision
    always_comb begin
        next_state = state;
        case (state)
            BSO_IDLE:
                if (enabled)
                    next_state = BSO_SETTLE;          // see RULE_01 RULE_02
            BSO_SETTLE:
                if (tmr == 18'(SETTLE_CYC - 1))
                    next_state = BSO_SAMPLE;          // see RULE_03
            BSO_SAMPLE:
                // higher setting counts longer before the compare flips
                if (!i_trip_set_pin_cmp || o_oc_dac == DAC_FULL ||
                    tmr == 18'(SAMPLE_CYC - 1))
                    next_state = BSO_SOFT;            // see RULE_05 RULE_07
            BSO_SOFT:
                if (oc_hit)
                    next_state = BSO_DUMMY;           // see RULE_14 RULE_19
                else if (o_ss_ref == DAC_FULL &&
                         step_tmr == step_len(SS_CYC) - 18'h1)
                    next_state = BSO_RUN;             // see RULE_08
            BSO_RUN:
                if (oc_hit)
                    next_state = BSO_DUMMY;           // see RULE_14
            BSO_DUMMY:
                // retries reuse the held set point, no resample
                if (dummy_cnt && o_ss_ref == DAC_FULL &&
                    step_tmr == step_len(SS_CYC) - 18'h1)
                    next_state = BSO_SOFT;            // see RULE_13 RULE_14
            default:
                next_state = BSO_IDLE;
        endcase
        if (!enabled)
            next_state = BSO_IDLE;                    // see RULE_12 RULE_17
    end

    // state register; reset returns to idle
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            state <= BSO_IDLE;                        // see RULE_20
        else
            state <= next_state;
    end

    // delay timer for settle, sample and error-amp init
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            tmr <= 18'h0;
        else if (next_state != state)
            tmr <= 18'h0;
        else if (tmr != 18'h3FFFF)
            tmr <= tmr + 18'h1;                       // see RULE_20
    end

    // soft-start ramp, used by real and dummy runs alike
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_ss_ref <= DAC_ZERO;
            step_tmr <= 18'h0;
        end else if (next_state != state && next_state != BSO_RUN) begin
            // run keeps the final code; every other move restarts
            o_ss_ref <= DAC_ZERO;
            step_tmr <= 18'h0;
        end else if (state == BSO_SOFT || state == BSO_DUMMY) begin
            if (step_tmr == step_len(SS_CYC) - 18'h1) begin
                step_tmr <= 18'h0;
                if (o_ss_ref != DAC_FULL)
                    o_ss_ref <= o_ss_ref + 6'h01;     // see RULE_08
                else if (state == BSO_DUMMY)
                    o_ss_ref <= DAC_ZERO;             // see RULE_14
            end else begin
                step_tmr <= step_tmr + 18'h1;
            end
        end
    end

    // dummy time-out count: two per hiccup cycle
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            dummy_cnt <= 1'b0;
        else if (state != BSO_DUMMY)
            dummy_cnt <= 1'b0;
        else if (o_ss_ref == DAC_FULL &&
                 step_tmr == step_len(SS_CYC) - 18'h1)
            dummy_cnt <= ~dummy_cnt;                  // see RULE_14
    end

    // set-point counter: climbs during sample, holds after
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_oc_dac <= DAC_ZERO;
            held     <= 1'b0;
        end else if (state == BSO_SETTLE) begin
            o_oc_dac <= DAC_ZERO;                     // see RULE_12
            held     <= 1'b0;
        end else if (state == BSO_SAMPLE) begin
            if (i_trip_set_pin_cmp && o_oc_dac != DAC_FULL &&
                (tmr % step_len(SAMPLE_CYC)) == 18'h0)
                o_oc_dac <= o_oc_dac + 6'h01;         // see RULE_05
            if (next_state != BSO_SAMPLE)
                held <= 1'b1;
        end else if (!i_por_ok) begin
            held <= 1'b0;                             // see RULE_06
        end
    end

    // pre-bias tracking and real-attempt flag
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            passed_vout <= 1'b0;
            real_run    <= 1'b0;
        end else if (state != BSO_SOFT && next_state == BSO_SOFT) begin
            passed_vout <= 1'b0;
            real_run    <= 1'b1;
        end else if (state == BSO_SOFT) begin
            if (!i_vout_gt_ss)
                passed_vout <= 1'b1;                  // see RULE_10
        end else if (state != BSO_RUN) begin
            real_run <= 1'b0;
        end
    end

    // error amp on after init interval; switching gated by pre-bias
    always_comb begin
        o_ea_en = (state == BSO_RUN) ||
                  (state == BSO_SOFT && tmr >= 18'(INIT_CYC));  // see RULE_09
        // enable gates at once, not one edge later with the state
        g.allow = enabled &&
                  ((state == BSO_RUN) ||
                   (state == BSO_SOFT && passed_vout &&
                    tmr >= 18'(INIT_CYC)));           // see RULE_10 RULE_11
        g.pwm_low = i_pwm_low & ~i_pwm_high;
    end

    // shaped low-side gate and current window
    bso_low_gate_shaper u_shaper (
        .i_mclk   (i_mclk),
        .i_rst    (i_rst),
        .i_period (i_period),
        .g        (g.shp)
    );

    // gate outputs off outside switching; trip shuts off at once
    // a stretched low pulse cuts the high side short: no shoot-through
    assign o_gate_high = g.allow & i_pwm_high & ~g.gate_low &
                         ~oc_hit;                         // see RULE_14
    assign o_gate_low  = g.gate_low & ~oc_hit;            // see RULE_04
    assign o_trip_set_pin_src  = (state == BSO_SETTLE) ||
                         (state == BSO_SAMPLE);           // see RULE_04
    assign o_osc_run   = enabled;                         // see RULE_17
    assign o_oc_trip   = oc_hit & real_run;
    assign o_ss_done   = (state == BSO_RUN) & held;
endmodule : bso_sequencer

// ### bso_stage_model.sv
// partner: power stage giving pwm requests and low-side current sense
module bso_stage_model (
    input  wire logic i_mclk,     // clock
    input  wire logic i_rst,      // reset, high
    input  wire logic i_short,    // output shorted when high
    input  wire logic i_gate_low, // low gate from sequencer
    input  wire logic i_narrow,   // drop the low request when high
    output logic      o_pwm_high, // raw high request
    output logic      o_pwm_low,  // raw low request
    output logic      o_period,   // period start pulse
    output logic      o_oc_cmp    // low-side current over trip
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PER_CYC = 42; // about 600 kHz at 25 MHz
    int unsigned cnt;
    logic        low_on;  // low switch conducted last cycle

    // wide low pulse outside narrow mode so the check window opens
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt    <= 0;
            low_on <= 1'b0;
        end else begin
            cnt    <= (cnt == PER_CYC - 1) ? 0 : cnt + 1;
            low_on <= i_gate_low;
        end
    end
    assign o_period   = (cnt == 0);
    assign o_pwm_high = (cnt < 12);
    // narrow mode: low request missing, as at very high duty
    assign o_pwm_low  = !i_narrow && (cnt >= 13);
    // current flows only through a conducting low switch; the sense
    // lags a cycle, a direct path would loop through the trip mask
    assign o_oc_cmp   = i_short && low_on;
endmodule : bso_stage_model

// ### tb_bso_sequencer.sv
// testbench: start-up, pre-bias, overcurrent and disable scenarios
module tb_bso_sequencer import bso_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 0, i_rst = 1, i_por_ok = 0, i_en_high = 0;
    logic i_trip_set_pin_cmp = 0, i_vout_gt_ss = 0, short_on = 0, narrow_on = 0;
    logic pwm_high, pwm_low, period, oc_cmp;
    logic [DAC_W-1:0] ss_ref, oc_dac, held;
    logic trip_set_pin_src, ea_en, osc_run, g_high, g_low, oc_trip, ss_done;
    int error_cnt = 0, samples_checked = 0, n;

    always #20 i_mclk = ~i_mclk;

    bso_stage_model u_stage (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_short(short_on), .i_gate_low(g_low), .i_narrow(narrow_on),
        .o_pwm_high(pwm_high),
        .o_pwm_low(pwm_low), .o_period(period), .o_oc_cmp(oc_cmp));
    bso_sequencer u_dut (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_por_ok(i_por_ok), .i_en_high(i_en_high), .i_trip_set_pin_cmp(i_trip_set_pin_cmp),
        .i_oc_cmp(oc_cmp), .i_vout_gt_ss(i_vout_gt_ss),
        .i_pwm_high(pwm_high), .i_pwm_low(pwm_low), .i_period(period),
        .o_ss_ref(ss_ref), .o_oc_dac(oc_dac), .o_trip_set_pin_src(trip_set_pin_src),
        .o_ea_en(ea_en), .o_osc_run(osc_run), .o_gate_high(g_high),
        .o_gate_low(g_low), .o_oc_trip(oc_trip), .o_ss_done(ss_done));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // inputs always move 1 ns after the rising edge
    task automatic step(input int k);
        repeat (k) @(posedge i_mclk);
        #1;
    endtask : step

    task automatic t_hold_off();
        i_por_ok = 1; // enable pulled low by the external driver
        step(50);
        check(osc_run, 1'b0);
        check(trip_set_pin_src, 1'b0);
        i_por_ok = 0;
        i_en_high = 1;
        step(50);
        check(trip_set_pin_src, 1'b0);
        $display("hold-off test done");
    endtask : t_hold_off

    task automatic t_startup();
        i_por_ok = 1;
        i_trip_set_pin_cmp = 1;
        step(2);
        check(trip_set_pin_src, 1'b1);
        check(g_low, 1'b0);
        n = 0;
        while (trip_set_pin_src === 1'b1 && n < 300000) begin
            step(1);
            n++;
            if (n == SETTLE_CYC + 6000) i_trip_set_pin_cmp = 0;
        end
        check(n >= SETTLE_CYC - 2, 1'b1);
        if (i_trip_set_pin_cmp) begin
            step(6000);
            i_trip_set_pin_cmp = 0;
        end
        // output sits above the early ramp: both switches stay off
        i_vout_gt_ss = 1;
        repeat (3000) begin
            step(1);
            check({g_high, g_low}, 2'b00);
        end
        i_vout_gt_ss = 0;
        check(ea_en, 1'b1);
        check(ss_done, 1'b0);
        n = 0;
        while (ss_done !== 1'b1 && n < SS_CYC + 2000) begin
            step(1);
            n++;
        end
        check(ss_done, 1'b1);
        check(ss_ref, DAC_FULL);
        // compare stayed high about 6000 cycles into the sample
        check(oc_dac, 6000 / (SAMPLE_CYC / SS_STEPS) + 1);
        held = oc_dac;
        step(100);
        check(oc_dac, held);
        $display("start-up test done");
    endtask : t_startup

    // low request missing: every third period gets a forced pulse
    task automatic t_narrow();
        int cnt_low;
        narrow_on = 1;
        step(300);
        while (period !== 1'b1)
            step(1);
        cnt_low = 0;
        // three switching periods of 42 cycles each
        repeat (126) begin
            step(1);
            if (g_low === 1'b1)
                cnt_low++;
            check(g_high & g_low, 1'b0);
        end
        check(cnt_low, MIN_LOW_CYC);
        narrow_on = 0;
        step(50);
        $display("narrow pulse test done");
    endtask : t_narrow

    task automatic t_trip();
        short_on = 1;
        n = 0;
        while (oc_trip !== 1'b1 && n < 500) begin
            step(1);
            n++;
        end
        check(oc_trip, 1'b1);
        step(1);
        check({g_high, g_low, ss_done}, 3'b000);
        short_on = 0;
        step(5000);
        check(ss_done, 1'b0);
        check(trip_set_pin_src, 1'b0);
        check(ss_ref, 5000 / (SS_CYC / SS_STEPS));
        check(oc_dac, held);
        $display("overcurrent test done");
    endtask : t_trip

    task automatic t_disable();
        i_en_high = 0;
        step(2);
        check(osc_run, 1'b0);
        check({g_high, g_low}, 2'b00);
        i_en_high = 1;
        step(3);
        check(trip_set_pin_src, 1'b1);
        $display("disable test done");
    endtask : t_disable

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // reset held for two cycles, then the scenarios in order
    initial begin
        step(2);
        i_rst = 0;
        t_hold_off();
        t_startup();
        t_narrow();
        t_trip();
        t_disable();
        test_done();
    end

    // the full run is about 350k cycles; cut a hang well beyond that
    initial begin
        #(40 * 800000);
        error_cnt++;
        test_done();
    end
endmodule : tb_bso_sequencer
